// ---- hdl/port_priority_tag_control.sv ----
// Per-port ingress/egress control register with its decisions.
// Assumes an Avalon-MM master on clock_i and a datapath that offers one
// packet decision at a time; all decision outputs are registered.
//
// Functional notes
// - Bit 7 enables broadcast storm protection.
// - Bit 6 enables DiffServ priority classification.
// - Bit 5 enables 802.1p priority classification.
// - Bits 4-3 give fallback port priority 0..3.
// - DiffServ and 802.1p results ORed override port.
// - Bit 2 tags untagged packets with ingress VID.
// - Already tagged packets get no extra tag.
// - Bit 1 strips tags from tagged packets.
// - Untagged packets pass unmodified under removal.
// - Bit 0 splits output into four queues.
// - Bit 0 clear gives one undifferentiated queue.
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ns
module port_priority_tag_control
   import port_ctrl_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Avalon-MM slave
   input wire logic [3:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   input wire logic [3:0] byteenable_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   // Ingress classification inputs
   input wire logic pkt_valid_i,
   input wire logic dscp_valid_i,
   input wire logic [1:0] dscp_pri_i,
   input wire logic dot1p_valid_i,
   input wire logic [1:0] dot1p_pri_i,
   input wire logic rx_tagged_i,
   input wire logic [11:0] ingress_vid_i,
   // Decisions
   output logic storm_protect_o,
   output logic dec_valid_o,
   output logic [1:0] pri_o,
   output logic [1:0] queue_o,
   output logic add_tag_o,
   output logic strip_tag_o,
   output logic [11:0] tag_vid_o
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      bus_state_t bus;
      logic [15:0] ctrl;
      logic [31:0] rdata;
      logic dec_valid;
      logic [1:0] pri;
      logic [1:0] queue;
      logic add_tag;
      logic strip_tag;
      logic [11:0] tag_vid;
      logic [7:0] pkt_count;
   } state_t;

   state_t state_r;
   state_t state_nxt;
   logic [1:0] cls_pri;
   logic cls_add;
   logic cls_strip;
   logic [1:0] cls_queue;

   function automatic logic [15:0] merge_bytes(input logic [15:0] old_v,
                                               input logic [31:0] wd,
                                               input logic [3:0] be);
      logic [15:0] v;
      v = old_v;
      if (be[0]) begin
         v[7:0] = wd[7:0];
      end
      if (be[1]) begin
         v[15:8] = wd[15:8];
      end
      // Upper byte is reserved and stays zero
      return v & CTRL_WRITE_MASK;
   endfunction

   // ****************************************
   // Decision logic
   // ****************************************
   priority_classifier u_cls (
      .dscp_en_i(state_r.ctrl[DSCP_EN_BIT]),
      .dot1p_en_i(state_r.ctrl[DOT1P_EN_BIT]),
      .port_pri_i(state_r.ctrl[PORT_PRI_HI:PORT_PRI_LO]),
      .dscp_valid_i(dscp_valid_i),
      .dscp_pri_i(dscp_pri_i),
      .dot1p_valid_i(dot1p_valid_i),
      .dot1p_pri_i(dot1p_pri_i),
      .pri_o(cls_pri)
   );

   egress_tag_ctrl u_egr (
      .tag_ins_en_i(state_r.ctrl[TAG_INS_BIT]),
      .tag_rem_en_i(state_r.ctrl[TAG_REM_BIT]),
      .multi_q_en_i(state_r.ctrl[MULTI_Q_BIT]),
      .rx_tagged_i(rx_tagged_i),
      .pri_i(cls_pri),
      .add_tag_o(cls_add),
      .strip_tag_o(cls_strip),
      .queue_o(cls_queue)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      state_nxt = state_r;
      state_nxt.dec_valid = 1'b0;
      if (pkt_valid_i) begin
         state_nxt.dec_valid = 1'b1;
         state_nxt.pri = cls_pri;
         state_nxt.queue = cls_queue;
         state_nxt.add_tag = cls_add;
         state_nxt.strip_tag = cls_strip;
         // Inserted tag carries the ingress port VID
         state_nxt.tag_vid = ingress_vid_i;
         state_nxt.pkt_count = state_r.pkt_count + 8'h01;
      end
      case (state_r.bus)
         BUS_IDLE: begin
            if (write_i) begin
               if (address_i == CTRL_REG_OFFSET) begin
                  state_nxt.ctrl = merge_bytes(state_r.ctrl, writedata_i, byteenable_i);
               end
               state_nxt.bus = BUS_ACK;
            end else if (read_i) begin
               case (address_i)
                  CTRL_REG_OFFSET: begin
                     state_nxt.rdata = {16'h0000, state_r.ctrl};
                  end
                  STATUS_REG_OFFSET: begin
                     state_nxt.rdata = {16'h0000, state_r.pkt_count,
                                        2'h0, state_r.queue, state_r.pri,
                                        state_r.add_tag, state_r.strip_tag};
                  end
                  default: begin
                     state_nxt.rdata = UNMAPPED_READ;
                  end
               endcase
               state_nxt.bus = BUS_ACK;
            end
         end
         BUS_ACK: begin
            state_nxt.bus = BUS_IDLE;
         end
         default: begin
            state_nxt.bus = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_r <= '{bus: BUS_IDLE, ctrl: CTRL_RESET, rdata: 32'h0000_0000,
                      dec_valid: 1'b0, pri: 2'h0, queue: 2'h0, add_tag: 1'b0,
                      strip_tag: 1'b0, tag_vid: 12'h000, pkt_count: 8'h00};
      end else if (ce_i) begin
         state_r <= state_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Wait one cycle so read data comes from a flip-flop; a frozen clock
   // enable must not complete a request that was never taken
   assign waitrequest_o = (read_i | write_i) & ~((state_r.bus == BUS_ACK) & ce_i);
   assign readdata_o = state_r.rdata;
   assign storm_protect_o = state_r.ctrl[STORM_EN_BIT];
   assign dec_valid_o = state_r.dec_valid;
   assign pri_o = state_r.pri;
   assign queue_o = state_r.queue;
   assign add_tag_o = state_r.add_tag;
   assign strip_tag_o = state_r.strip_tag;
   assign tag_vid_o = state_r.tag_vid;
endmodule

// ---- hdl/port_ctrl_pkg.sv ----
// Package for the per-port ingress/egress control block.
// Assumes a 16-bit control register reached over a 32-bit Avalon-MM slave.
package port_ctrl_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [3:0] CTRL_REG_OFFSET = 4'h0;
   localparam logic [3:0] STATUS_REG_OFFSET = 4'h4;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CTRL_WRITE_MASK = 16'h00ff;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int STORM_EN_BIT = 7;
   localparam int DSCP_EN_BIT = 6;
   localparam int DOT1P_EN_BIT = 5;
   localparam int PORT_PRI_HI = 4;
   localparam int PORT_PRI_LO = 3;
   localparam int TAG_INS_BIT = 2;
   localparam int TAG_REM_BIT = 1;
   localparam int MULTI_Q_BIT = 0;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK = 2'b01
   } bus_state_t;
endpackage

// ---- hdl/priority_classifier.sv ----
// Ingress priority classifier for one port.
// Assumes DSCP and 802.1p mapped priorities come from outside logic.
`timescale 1ns/1ns
module priority_classifier
   import port_ctrl_pkg::*;
(
   input wire logic dscp_en_i,
   input wire logic dot1p_en_i,
   input wire logic [1:0] port_pri_i,
   input wire logic dscp_valid_i,
   input wire logic [1:0] dscp_pri_i,
   input wire logic dot1p_valid_i,
   input wire logic [1:0] dot1p_pri_i,
   output logic [1:0] pri_o
);
   logic use_dscp;
   logic use_dot1p;
   always_comb begin
      use_dscp = dscp_en_i & dscp_valid_i;
      use_dot1p = dot1p_en_i & dot1p_valid_i;
      if (use_dscp | use_dot1p) begin
         // Both sources OR together and override the port value
         pri_o = (use_dscp ? dscp_pri_i : 2'h0) | (use_dot1p ? dot1p_pri_i : 2'h0);
      end else begin
         pri_o = port_pri_i;
      end
   end
endmodule

// ---- hdl/egress_tag_ctrl.sv ----
// Egress tag and queue decision for one port.
// Assumes tag state and VID of the ingress port come from the datapath.
`timescale 1ns/1ns
module egress_tag_ctrl
   import port_ctrl_pkg::*;
(
   input wire logic tag_ins_en_i,
   input wire logic tag_rem_en_i,
   input wire logic multi_q_en_i,
   input wire logic rx_tagged_i,
   input wire logic [1:0] pri_i,
   output logic add_tag_o,
   output logic strip_tag_o,
   output logic [1:0] queue_o
);
   always_comb begin
      add_tag_o = tag_ins_en_i & ~rx_tagged_i;
      strip_tag_o = tag_rem_en_i & rx_tagged_i;
      queue_o = multi_q_en_i ? pri_i : 2'h0;
   end
endmodule

// ---- bench/port_ctrl_properties.sv ----
// Assertions on the ports of the port control block.
// Assumes ce_i stays high; bound into port_priority_tag_control by the bind below.
`timescale 1ns/1ns
module port_ctrl_properties
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [3:0] address_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   input wire logic [3:0] byteenable_i,
   input wire logic waitrequest_o,
   input wire logic pkt_valid_i,
   input wire logic dscp_valid_i,
   input wire logic [1:0] dscp_pri_i,
   input wire logic dot1p_valid_i,
   input wire logic [1:0] dot1p_pri_i,
   input wire logic rx_tagged_i,
   input wire logic [11:0] ingress_vid_i,
   input wire logic storm_protect_o,
   input wire logic dec_valid_o,
   input wire logic [1:0] pri_o,
   input wire logic [1:0] queue_o,
   input wire logic add_tag_o,
   input wire logic strip_tag_o,
   input wire logic [11:0] tag_vid_o
);
   logic [7:0] sh_r;
   wire wr_go = write_i && !waitrequest_o && address_i == 4'h0 && byteenable_i[0];
   wire take = pkt_valid_i && ce_i;
   wire hd = sh_r[6] & dscp_valid_i;
   wire ht = sh_r[5] & dot1p_valid_i;
   wire [1:0] ep = (hd | ht) ? (({2{hd}} & dscp_pri_i) | ({2{ht}} & dot1p_pri_i)) : sh_r[4:3];
   // Sampled so the combinational waitrequest cannot race the edge
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sh_r <= 8'h00;
      end else if ($sampled(wr_go)) begin
         sh_r <= $sampled(writedata_i[7:0]);
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff rst_i;
   property p_storm; !write_i |-> storm_protect_o == sh_r[7]; endproperty
   a_storm: assert property (p_storm)
      else $error("storm enable differs from control");
   property p_pri; take |=> pri_o == $past(ep); endproperty
   a_pri: assert property (p_pri)
      else $error("classified priority wrong");
   property p_port; take && !hd && !ht |=> pri_o == $past(sh_r[4:3]); endproperty
   a_port: assert property (p_port)
      else $error("port priority fallback wrong");
   property p_multi; dec_valid_o && sh_r[0] |-> queue_o == pri_o; endproperty
   a_multi: assert property (p_multi)
      else $error("queue does not follow priority");
   property p_single; dec_valid_o && !sh_r[0] |-> queue_o == 2'h0; endproperty
   a_single: assert property (p_single)
      else $error("single queue mode used other queue");
   property p_ins; take |=> add_tag_o == $past(sh_r[2] && !rx_tagged_i); endproperty
   a_ins: assert property (p_ins)
      else $error("tag insertion decision wrong");
   property p_vid; take && sh_r[2] && !rx_tagged_i |=> tag_vid_o == $past(ingress_vid_i); endproperty
   a_vid: assert property (p_vid)
      else $error("inserted tag id wrong");
   property p_rem; take |=> strip_tag_o == $past(sh_r[1] && rx_tagged_i); endproperty
   a_rem: assert property (p_rem)
      else $error("tag removal decision wrong");
   c_wr: cover property (wr_go);
   c_mix: cover property (take && hd && ht);
   c_tag: cover property (dec_valid_o && add_tag_o);
endmodule
bind port_priority_tag_control port_ctrl_properties u_props (.*);

// ---- bench/port_priority_tag_control_tb_top.sv ----
// Self-checking bench for the port control block.
// Assumes the design answers the bus and decisions as its note states.
`timescale 1ns/1ns
`define CHK(n, x, y) begin cmp_count++; if ((y) !== (x)) begin n_errors++; \
   $display("CHECK FAILED %s expected %h seen %h", n, x, y); end end
module port_priority_tag_control_tb_top;
   logic clock_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, read_i = 1'b0, write_i = 1'b0;
   logic pkt_valid_i = 1'b0, dscp_valid_i = 1'b0, dot1p_valid_i = 1'b0, rx_tagged_i = 1'b0;
   logic [3:0] address_i = 4'h0, byteenable_i = 4'h0;
   logic [1:0] dscp_pri_i = 2'h0, dot1p_pri_i = 2'h0, pri_o, queue_o;
   logic [11:0] ingress_vid_i = 12'h000, tag_vid_o;
   logic [31:0] writedata_i = 32'h0000_0000, readdata_o, e;
   logic waitrequest_o, storm_protect_o, dec_valid_o, add_tag_o, strip_tag_o;
   logic [7:0] c = 8'h00, cnt = 8'h00;
   logic [18:0] ld = 19'h0_0000;
   logic [31:0] exp_q[$];
   int n_errors = 0, cmp_count = 0, cyc = 0;
   wire [31:0] seen = {13'h0000, storm_protect_o, pri_o, queue_o, add_tag_o, strip_tag_o,
      add_tag_o ? tag_vid_o : 12'h000};
   port_priority_tag_control uut (.*);
   always #25 clock_i = ~clock_i;
   task complete_run;
      if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   function automatic logic [18:0] dexp(input logic [18:0] r);
      logic hd, ht;
      logic [1:0] p;
      hd = c[6] & r[18];
      ht = c[5] & r[15];
      p = (hd | ht) ? (({2{hd}} & r[17:16]) | ({2{ht}} & r[14:13])) : c[4:3];
      return {c[7], p, c[0] ? p : 2'h0, c[2] & !r[12], c[1] & r[12],
         (c[2] & !r[12]) ? r[11:0] : 12'h000};
   endfunction
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
      @(posedge clock_i);
      write_i <= w;
      read_i <= !w;
      address_i <= a;
      writedata_i <= d;
      byteenable_i <= b;
      do @(posedge clock_i); while (waitrequest_o);
      write_i <= 1'b0;
      read_i <= 1'b0;
   endtask
   // Valid stays high across the burst to drive back-to-back decisions
   task automatic burst(input int n);
      logic [31:0] r;
      repeat (n) begin
         @(posedge clock_i);
         r = $urandom;
         {dscp_valid_i, dscp_pri_i, dot1p_valid_i, dot1p_pri_i, rx_tagged_i, ingress_vid_i} <= r[18:0];
         pkt_valid_i <= 1'b1;
         ld = dexp(r[18:0]);
         exp_q.push_back({13'h0000, ld});
         cnt = cnt + 8'h01;
      end
      @(posedge clock_i);
      pkt_valid_i <= 1'b0;
   endtask
   always @(posedge clock_i) begin
      if ((read_i && !waitrequest_o) || dec_valid_o) e = exp_q.size() ? exp_q.pop_front() : 32'hxxxx_xxxx;
      if (read_i && !waitrequest_o) `CHK("readdata", e, readdata_o)
      if (dec_valid_o) `CHK("decision", e, seen)
   end
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         complete_run;
      end
   end
   initial begin
      logic [31:0] d;
      logic [3:0] b;
      void'($urandom(61751));
      repeat (20) @(posedge clock_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 40; i++) begin
         d = $urandom;
         b = $urandom;
         if (b[0]) c = d[7:0];
         bus(1'b1, 4'h0, d, b);
         burst(1 + i % 4);
         exp_q.push_back({16'h0000, cnt, 2'h0, ld[15:14], ld[17:16], ld[13:12]});
         bus(1'b0, 4'h4, d, 4'hf);
         bus(1'b1, 4'hc, ~d, 4'hf);
         exp_q.push_back({24'h00_0000, c});
         bus(1'b0, 4'h0, d, 4'hf);
         exp_q.push_back(32'h0000_0000);
         if (i == 20) begin
            // Clock enable low must hold the request unanswered
            ce_i <= 1'b0;
            fork
               bus(1'b0, 4'h8, d, 4'hf);
               begin
                  repeat (3) @(posedge clock_i);
                  ce_i <= 1'b1;
               end
            join
         end else begin
            bus(1'b0, 4'h8, d, 4'hf);
         end
      end
      repeat (3) @(posedge clock_i);
      if (exp_q.size() != 0) n_errors++;
      complete_run;
   end
endmodule
